// ==== src/aux_pin_mux_consts.vh ====
// constants for the auxiliary pin function selector
`ifndef AUX_PIN_MUX_CONSTS_VH
`define AUX_PIN_MUX_CONSTS_VH

// pin counts and select code width
`define AUX_PIN_COUNT        6
`define AUX_GPIO_PIN_COUNT   4
`define AUX_SEL_W            5

// per-pin function select codes
`define SEL_HIGH_Z           5'h00
`define SEL_DRIVE_ONE        5'h01
`define SEL_DRIVE_ZERO       5'h02
`define SEL_POWER_ENABLE     5'h03
`define SEL_SLEEP            5'h04
`define SEL_CLK_FAST         5'h05
`define SEL_CLK_MID          5'h06
`define SEL_CLK_SLOW         5'h07
`define SEL_GPIO             5'h08
`define SEL_CHARGER          5'h09
`define SEL_CHARGER_N        5'h0a
`define SEL_BB_WRITE         5'h0b
`define SEL_BB_READ          5'h0c
`define SEL_TX_EMPTY         5'h0d
`define SEL_RX_FULL          5'h0e
`define SEL_BUS_POWER        5'h0f
`define SEL_TIMESTAMP        5'h10
`define SEL_KEEP_AWAKE       5'h11

// reset values
`define POWER_ENABLE_N_RST   1'b1
`define SLEEP_N_RST          1'b1
`define TIMESTAMP_RST        1'b0

// clock output frequencies and system clock, in kHz
`define SYS_CLK_KHZ          50000
`define CLK_FAST_KHZ         24000
`define CLK_MID_KHZ          12000
`define CLK_SLOW_KHZ         6000

// phase accumulator width for the clock outputs
`define NCO_W                16

`endif

// ==== src/clk_nco.v ====
// phase-accumulator square wave generator for one clock output
`timescale 1ns/10ps
module clk_nco #(
    parameter [15:0] INC = 16'h0000
) (
    // clock and reset
    input  wire        clk,
    input  wire        rstn,
    // control
    input  wire        run,
    // clock output
    output reg         clk_q
);

    reg  [15:0] acc_q;
    wire [16:0] sum;

    assign sum = {1'b0, acc_q} + {1'b0, INC};

    // a carry means half a period has elapsed; stopping clears phase so
    // the output restarts cleanly low after suspend
    always @(posedge clk) begin
        if (!rstn || !run) begin
            acc_q <= 16'h0000;
            clk_q <= 1'b0;
        end else begin
            acc_q <= sum[15:0];
            if (sum[16]) begin
                clk_q <= ~clk_q;
            end
        end
    end

endmodule

// ==== src/configurable_aux_pin_mux.v ====
// function selector for the six configurable auxiliary pins
//
// How it works
// RULE1: each pin takes its own function chosen in stored config, per pin.
// RULE2: high impedance disables driver; constant level drives steady 1 or 0.
// RULE3: power enable goes low once configured, back high in suspend.
// RULE4: boards switching a p-channel switch should enable the pull-down.
// RULE5: sleep indicator is low during suspend, high otherwise.
// RULE6: clock function gives free-running 24, 12 or 6 MHz.
// RULE7: every clock output stops toggling during suspend.
// RULE8: general-purpose i/o exists only on the first four pins, each alone.
// RULE9: charger output is high when on a dedicated charger, else low.
// RULE10: inverted charger output is open drain, pulling low when asserted.
// RULE11: write strobe option outputs the internal active-low write strobe.
// RULE12: read strobe option outputs the internal active-low read strobe.
// RULE13: transmit-empty flag tells the i2c master the tx buffer is empty.
// RULE14: receive-full flag tells the i2c master the rx buffer is full.
// RULE15: bus-power sense pin is an input deciding bus power presence.
// RULE16: timestamp output inverts once per start-of-frame packet.
// RULE17: keep-awake input held low blocks suspend after unplug.
// RULE18: all hash-marked functions are asserted low.
// RULE19: input pins pull weakly up; option pulls gently low in suspend.
// RULE20: per-pin select code loaded after reset; high-z until loaded.
// RULE21: invalid codes, or gpio on pins five and six, act as high-z.
`timescale 1ns/10ps
`include "aux_pin_mux_consts.vh"
module configurable_aux_pin_mux #(
    parameter NPINS = `AUX_PIN_COUNT,
    parameter NGPIO = `AUX_GPIO_PIN_COUNT
) (
    // clock and reset
    input  wire                      clk,
    input  wire                      rstn,
    // configuration load from nonvolatile memory
    input  wire                      cfg_load,
    input  wire [NPINS*5-1:0]        cfg_sel,
    input  wire                      cfg_suspend_pull_down,
    output reg                       cfg_loaded_q,
    // usb engine status
    input  wire                      usb_configured,
    input  wire                      usb_suspend,
    input  wire                      sof_pulse,
    input  wire                      charger_detect,
    // bit-bang engine
    input  wire                      bitbang_write_strobe_n,
    input  wire                      bitbang_read_strobe_n,
    input  wire [NGPIO-1:0]          gpio_out,
    input  wire [NGPIO-1:0]          gpio_oe,
    output reg  [NGPIO-1:0]          gpio_in_q,
    // buffer status
    input  wire                      tx_empty,
    input  wire                      rx_full,
    // decisions handed back to the core
    output reg                       bus_power_sense_used_q,
    output reg                       bus_power_present_q,
    output reg                       suspend_inhibit_q,
    output reg                       power_enable_n_q,
    // auxiliary pins
    input  wire [NPINS-1:0]          aux_pin_in,
    output reg  [NPINS-1:0]          aux_pin_out_q,
    output reg  [NPINS-1:0]          aux_pin_oe_q,
    output reg  [NPINS-1:0]          aux_pin_pull_up_q,
    output reg  [NPINS-1:0]          aux_pin_pull_down_q
);

    localparam integer INC_FAST =
        (`CLK_FAST_KHZ * 65536) / (`SYS_CLK_KHZ / 2);
    localparam integer INC_MID  =
        (`CLK_MID_KHZ * 65536) / (`SYS_CLK_KHZ / 2);
    localparam integer INC_SLOW =
        (`CLK_SLOW_KHZ * 65536) / (`SYS_CLK_KHZ / 2);

    // pin input synchroniser
    reg  [NPINS-1:0]          pin_meta_q;
    reg  [NPINS-1:0]          pin_sync_q;

    // stored per-pin select codes
    reg  [NPINS*5-1:0]        sel_q;
    reg                       pull_down_opt_q;

    // internal function levels
    reg                       sleep_n_q;
    reg                       timestamp_q;
    wire                      clk_fast;
    wire                      clk_mid;
    wire                      clk_slow;
    wire                      clk_run;

    // per-pin next values
    reg  [NPINS-1:0]          out_d;
    reg  [NPINS-1:0]          oe_d;
    reg  [NPINS-1:0]          pu_d;
    reg  [NPINS-1:0]          pd_d;
    reg  [NPINS-1:0]          is_sense;
    reg  [NPINS-1:0]          sense_high;
    reg  [NPINS-1:0]          is_awake;
    reg  [NPINS-1:0]          awake_low;
    reg  [NGPIO-1:0]          gpio_in_d;

    always @(posedge clk) begin
        if (!rstn) begin
            pin_meta_q <= {NPINS{1'b0}};
            pin_sync_q <= {NPINS{1'b0}};
        end else begin
            pin_meta_q <= aux_pin_in;
            pin_sync_q <= pin_meta_q;
        end
    end

    // config load: codes are cleaned once here so the mux never sees a
    // code it cannot serve
    genvar g;
    generate
        for (g = 0; g < NPINS; g = g + 1) begin : g_sel
            wire [4:0] raw;
            reg  [4:0] clean;
            assign raw = cfg_sel[g*5 +: 5];
            always @* begin
                clean = raw;
                if (raw > `SEL_KEEP_AWAKE) begin
                    clean = `SEL_HIGH_Z;                      // [RULE21]
                end
                if (raw == `SEL_GPIO && g >= NGPIO) begin
                    clean = `SEL_HIGH_Z;                // [RULE8] [RULE21]
                end
            end
            always @(posedge clk) begin
                if (!rstn) begin
                    sel_q[g*5 +: 5] <= `SEL_HIGH_Z;           // [RULE20]
                end else if (cfg_load) begin
                    sel_q[g*5 +: 5] <= clean;                  // [RULE1]
                end
            end
        end
    endgenerate

    always @(posedge clk) begin
        if (!rstn) begin
            cfg_loaded_q    <= 1'b0;
            pull_down_opt_q <= 1'b0;
        end else if (cfg_load) begin
            cfg_loaded_q    <= 1'b1;                          // [RULE20]
            pull_down_opt_q <= cfg_suspend_pull_down;          // [RULE19]
        end
    end

    // power and suspend indicators
    always @(posedge clk) begin
        if (!rstn) begin
            power_enable_n_q <= `POWER_ENABLE_N_RST;
            sleep_n_q        <= `SLEEP_N_RST;
        end else begin
            if (usb_suspend) begin
                power_enable_n_q <= 1'b1;                     // [RULE3]
            end else if (usb_configured) begin
                power_enable_n_q <= 1'b0;              // [RULE3] [RULE18]
            end
            sleep_n_q <= ~usb_suspend;                 // [RULE5] [RULE18]
        end
    end

    // frame timestamp toggle
    always @(posedge clk) begin
        if (!rstn) begin
            timestamp_q <= `TIMESTAMP_RST;
        end else if (sof_pulse) begin
            timestamp_q <= ~timestamp_q;                     // [RULE16]
        end
    end

    // clock outputs: synthesised from the 50 MHz clock; truncated increments put the average
    // frequency just below target and each edge carries up to one cycle of jitter
    assign clk_run = ~usb_suspend;                            // [RULE7]

    clk_nco #(
        .INC (INC_FAST[15:0])
    ) u_clk_fast (
        .clk   (clk),
        .rstn  (rstn),
        .run   (clk_run),
        .clk_q (clk_fast)
    );

    clk_nco #(
        .INC (INC_MID[15:0])
    ) u_clk_mid (
        .clk   (clk),
        .rstn  (rstn),
        .run   (clk_run),
        .clk_q (clk_mid)
    );

    clk_nco #(
        .INC (INC_SLOW[15:0])
    ) u_clk_slow (
        .clk   (clk),
        .rstn  (rstn),
        .run   (clk_run),
        .clk_q (clk_slow)
    );

    // per-pin function mux; one extra register stage before the pad
    generate
        for (g = 0; g < NPINS; g = g + 1) begin : g_pin
            wire [4:0] sel;
            wire       gpio_dir;
            wire       gpio_lvl;
            assign sel = sel_q[g*5 +: 5];
            if (g < NGPIO) begin : g_gp
                assign gpio_dir = gpio_oe[g];
                assign gpio_lvl = gpio_out[g];
            end else begin : g_nogp
                assign gpio_dir = 1'b0;
                assign gpio_lvl = 1'b0;
            end
            always @* begin
                out_d[g]      = 1'b0;
                oe_d[g]       = 1'b0;
                is_sense[g]   = 1'b0;
                is_awake[g]   = 1'b0;
                sense_high[g] = pin_sync_q[g];
                awake_low[g]  = ~pin_sync_q[g];
                case (sel)
                    `SEL_HIGH_Z: begin
                        oe_d[g] = 1'b0;                       // [RULE2]
                    end
                    `SEL_DRIVE_ONE: begin
                        out_d[g] = 1'b1;                      // [RULE2]
                        oe_d[g]  = 1'b1;
                    end
                    `SEL_DRIVE_ZERO: begin
                        out_d[g] = 1'b0;                      // [RULE2]
                        oe_d[g]  = 1'b1;
                    end
                    `SEL_POWER_ENABLE: begin
                        out_d[g] = power_enable_n_q;          // [RULE3]
                        oe_d[g]  = 1'b1;
                    end
                    `SEL_SLEEP: begin
                        out_d[g] = sleep_n_q;                 // [RULE5]
                        oe_d[g]  = 1'b1;
                    end
                    `SEL_CLK_FAST: begin
                        out_d[g] = clk_fast;                  // [RULE6]
                        oe_d[g]  = 1'b1;
                    end
                    `SEL_CLK_MID: begin
                        out_d[g] = clk_mid;                   // [RULE6]
                        oe_d[g]  = 1'b1;
                    end
                    `SEL_CLK_SLOW: begin
                        out_d[g] = clk_slow;                  // [RULE6]
                        oe_d[g]  = 1'b1;
                    end
                    `SEL_GPIO: begin
                        out_d[g] = gpio_lvl;                  // [RULE8]
                        oe_d[g]  = gpio_dir;
                    end
                    `SEL_CHARGER: begin
                        out_d[g] = charger_detect;            // [RULE9]
                        oe_d[g]  = 1'b1;
                    end
                    `SEL_CHARGER_N: begin
                        // open drain: drive only the low level
                        out_d[g] = 1'b0;                     // [RULE10]
                        oe_d[g]  = charger_detect;           // [RULE10]
                    end
                    `SEL_BB_WRITE: begin
                        out_d[g] = bitbang_write_strobe_n;   // [RULE11]
                        oe_d[g]  = 1'b1;
                    end
                    `SEL_BB_READ: begin
                        out_d[g] = bitbang_read_strobe_n;    // [RULE12]
                        oe_d[g]  = 1'b1;
                    end
                    `SEL_TX_EMPTY: begin
                        out_d[g] = ~tx_empty;         // [RULE13] [RULE18]
                        oe_d[g]  = 1'b1;
                    end
                    `SEL_RX_FULL: begin
                        out_d[g] = ~rx_full;          // [RULE14] [RULE18]
                        oe_d[g]  = 1'b1;
                    end
                    `SEL_BUS_POWER: begin
                        is_sense[g] = 1'b1;                  // [RULE15]
                    end
                    `SEL_TIMESTAMP: begin
                        out_d[g] = timestamp_q;              // [RULE16]
                        oe_d[g]  = 1'b1;
                    end
                    `SEL_KEEP_AWAKE: begin
                        is_awake[g] = 1'b1;           // [RULE17] [RULE18]
                    end
                    default: begin
                        oe_d[g] = 1'b0;                      // [RULE21]
                    end
                endcase
                // an undriven pad is an input; pull-down option swaps the
                // pull in suspend to stop leakage into a powered-off board
                if (!oe_d[g] && sel != `SEL_CHARGER_N) begin
                    if (pull_down_opt_q && usb_suspend) begin
                        pu_d[g] = 1'b0;                      // [RULE19]
                        pd_d[g] = 1'b1;
                    end else begin
                        pu_d[g] = 1'b1;                      // [RULE19]
                        pd_d[g] = 1'b0;
                    end
                end else begin
                    pu_d[g] = 1'b0;
                    pd_d[g] = 1'b0;
                end
            end
        end
    endgenerate

    // gpio read-back for the bit-bang engine
    generate
        for (g = 0; g < NGPIO; g = g + 1) begin : g_gin
            always @* begin
                if (sel_q[g*5 +: 5] == `SEL_GPIO) begin
                    gpio_in_d[g] = pin_sync_q[g];             // [RULE8]
                end else begin
                    gpio_in_d[g] = 1'b0;
                end
            end
        end
    endgenerate

    always @(posedge clk) begin
        if (!rstn) begin
            aux_pin_out_q          <= {NPINS{1'b0}};
            aux_pin_oe_q           <= {NPINS{1'b0}};          // [RULE20]
            aux_pin_pull_up_q      <= {NPINS{1'b1}};
            aux_pin_pull_down_q    <= {NPINS{1'b0}};
            gpio_in_q              <= {NGPIO{1'b0}};
            bus_power_sense_used_q <= 1'b0;
            bus_power_present_q    <= 1'b0;
            suspend_inhibit_q      <= 1'b0;
        end else begin
            aux_pin_out_q          <= out_d;
            aux_pin_oe_q           <= oe_d;                    // [RULE2]
            aux_pin_pull_up_q      <= pu_d;
            aux_pin_pull_down_q    <= pd_d;
            gpio_in_q              <= gpio_in_d;
            bus_power_sense_used_q <= |is_sense;               // [RULE15]
            bus_power_present_q    <= |(is_sense & sense_high);
            suspend_inhibit_q      <= |(is_awake & awake_low); // [RULE17]
        end
    end

endmodule

// ==== verif/aux_pin_mux_checker.sv ====
// assertion checker for the auxiliary pin selector
`timescale 1ns/10ps
`include "aux_pin_mux_consts.vh"
module aux_pin_mux_checker #(
    parameter NPINS = 6,
    parameter NGPIO = 4
) (
    // clock and reset
    input wire               clk,
    input wire               rstn,
    // core side inputs
    input wire               cfg_load,
    input wire [NPINS*5-1:0] cfg_sel,
    input wire               usb_suspend,
    input wire               sof_pulse,
    input wire               charger_detect,
    input wire               bitbang_write_strobe_n,
    input wire               bitbang_read_strobe_n,
    input wire [NGPIO-1:0]   gpio_out,
    input wire [NGPIO-1:0]   gpio_oe,
    // outputs
    input wire               cfg_loaded_q,
    input wire               power_enable_n_q,
    input wire [NPINS-1:0]   aux_pin_out_q,
    input wire [NPINS-1:0]   aux_pin_oe_q,
    input wire [NPINS-1:0]   aux_pin_pull_up_q,
    input wire [NPINS-1:0]   aux_pin_pull_down_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // sd_q is the selection that governs the pad values seen now
    reg  [NPINS*5-1:0] sel_q;
    reg  [NPINS*5-1:0] sd_q;
    wire [NPINS-1:0]   goe = {{(NPINS-NGPIO){1'b0}}, gpio_oe};
    wire [NPINS-1:0]   gout = {{(NPINS-NGPIO){1'b0}}, gpio_out};
    always @(posedge clk) begin
        if (!rstn) begin
            sel_q <= {(NPINS*5){1'b0}};
            sd_q  <= {(NPINS*5){1'b0}};
        end else begin
            if (cfg_load)
                sel_q <= cfg_sel;
            sd_q <= sel_q;
        end
    end
    property p_loaded;
        cfg_load |=> cfg_loaded_q;
    endproperty
    a_loaded: assert property (p_loaded)
        else $error("load not acknowledged");
    property p_pwr;
        usb_suspend |=> power_enable_n_q;
    endproperty
    a_pwr: assert property (p_pwr)
        else $error("power enable active in suspend");
    genvar i;
    generate
        for (i = 0; i < NPINS; i = i + 1) begin : g_pin
            wire [4:0] s = sd_q[5*i +: 5];
            wire       o = aux_pin_out_q[i];
            wire       e = aux_pin_oe_q[i];
            property p_hiz;
                s == `SEL_HIGH_Z || s > `SEL_KEEP_AWAKE ||
                (s == `SEL_GPIO && i >= NGPIO) |-> !e;
            endproperty
            a_hiz: assert property (p_hiz)
                else $error("pin driven while off");
            property p_level;
                s == `SEL_DRIVE_ONE || s == `SEL_DRIVE_ZERO
                |-> e && o == (s == `SEL_DRIVE_ONE);
            endproperty
            a_level: assert property (p_level)
                else $error("constant level wrong");
            property p_strobe;
                s == `SEL_BB_WRITE || s == `SEL_BB_READ |-> e &&
                o == (s == `SEL_BB_WRITE ? $past(bitbang_write_strobe_n)
                                          : $past(bitbang_read_strobe_n));
            endproperty
            a_strobe: assert property (p_strobe)
                else $error("strobe not passed");
            property p_odrain;
                s == `SEL_CHARGER_N |-> !o && e == $past(charger_detect);
            endproperty
            a_odrain: assert property (p_odrain)
                else $error("open drain charger wrong");
            property p_sleep;
                s == `SEL_SLEEP |-> e && o == !$past(usb_suspend, 2);
            endproperty
            a_sleep: assert property (p_sleep)
                else $error("sleep indicator wrong");
            property p_pwr_pin;
                s == `SEL_POWER_ENABLE |-> e && o == $past(power_enable_n_q);
            endproperty
            a_pwr_pin: assert property (p_pwr_pin)
                else $error("power enable pin wrong");
            property p_clk_stop;
                s >= `SEL_CLK_FAST && s <= `SEL_CLK_SLOW &&
                $past(usb_suspend, 2) && $past(usb_suspend, 3) &&
                $past(usb_suspend, 4) |-> e && !o;
            endproperty
            a_clk_stop: assert property (p_clk_stop)
                else $error("clock runs in suspend");
            property p_gpio;
                s == `SEL_GPIO && i < NGPIO |-> e == $past(goe[i]) &&
                (!e || o == $past(gout[i]));
            endproperty
            a_gpio: assert property (p_gpio)
                else $error("gpio pad wrong");
            property p_ts;
                s == `SEL_TIMESTAMP && $past(s) == `SEL_TIMESTAMP
                |-> e && ((o != $past(o)) == $past(sof_pulse, 2));
            endproperty
            a_ts: assert property (p_ts)
                else $error("timestamp toggle wrong");
            property p_pull;
                !e && s != `SEL_CHARGER_N && !$past(usb_suspend)
                |-> aux_pin_pull_up_q[i] && !aux_pin_pull_down_q[i];
            endproperty
            a_pull: assert property (p_pull)
                else $error("input pull wrong");
        end
    endgenerate
endmodule

bind configurable_aux_pin_mux aux_pin_mux_checker #(
    .NPINS(NPINS), .NGPIO(NGPIO)
) aux_pin_mux_checker_inst (
    .clk, .rstn, .cfg_load, .cfg_sel, .usb_suspend, .sof_pulse,
    .charger_detect, .bitbang_write_strobe_n, .bitbang_read_strobe_n,
    .gpio_out, .gpio_oe, .cfg_loaded_q, .power_enable_n_q,
    .aux_pin_out_q, .aux_pin_oe_q, .aux_pin_pull_up_q,
    .aux_pin_pull_down_q
);

// ==== verif/aux_board.sv ====
// board side of the pins: external drivers, resistors, floating lines
`timescale 1ns/10ps
module aux_board #(
    parameter [5:0] BOARD_PD = 6'h00
) (
    // clock
    input  wire       clk,
    // pad controls from the selector
    input  wire [5:0] out,
    input  wire [5:0] oe,
    input  wire [5:0] pu,
    input  wire [5:0] pd,
    // board drivers
    input  wire [5:0] ext_en,
    input  wire [5:0] ext_val,
    // resolved pin level
    output wire [5:0] lvl
);
    reg  [5:0] lvl_q = 6'h00;
    wire [5:0] idle = ~oe & ~ext_en;
    // resistor on the power switch gate holds it low when undriven and not pulled up
    wire [5:0] low = pd | BOARD_PD;
    // an undriven pin with no pull flips each cycle, never a stale level
    assign lvl = (oe & out) | (~oe & ext_en & ext_val) | (idle & pu) |
                 (idle & ~pu & ~low & ~lvl_q);
    always @(posedge clk)
        lvl_q <= lvl;
endmodule

// ==== verif/configurable_aux_pin_mux_tb.sv ====
// self-checking bench for the auxiliary pin selector
`timescale 1ns/10ps
`include "aux_pin_mux_consts.vh"
module configurable_aux_pin_mux_tb;
    reg         clk = 1'b0;
    reg         rstn = 1'b0;
    reg         ld = 1'b0;
    reg  [29:0] sel = 30'h0;
    reg         pd_opt = 1'b0;
    reg         ucfg = 1'b0;
    reg         usus = 1'b0;
    reg         sof = 1'b0;
    reg         chg = 1'b0;
    reg         wr_n = 1'b1;
    reg         rd_n = 1'b1;
    reg  [3:0]  g_out = 4'h0;
    reg  [3:0]  g_oe = 4'h0;
    reg         txe = 1'b0;
    reg         rxf = 1'b0;
    reg  [5:0]  ext_en = 6'h00;
    reg  [5:0]  ext_val = 6'h00;
    reg  [5:0]  prev = 6'h00;
    wire [5:0]  pin, out, oe, pu, pd;
    wire [3:0]  g_in;
    wire        loaded, bp_used, bp_on, inhibit, pwr_n;
    integer     n_errors = 0;
    integer     checked = 0;
    integer     cyc = 0;
    integer     cnt [0:5];
    integer     base [0:5];
    integer     k, j, e, m;

    always #10 clk = ~clk;

    configurable_aux_pin_mux configurable_aux_pin_mux_inst (
        .clk(clk), .rstn(rstn), .cfg_load(ld), .cfg_sel(sel),
        .cfg_suspend_pull_down(pd_opt), .cfg_loaded_q(loaded),
        .usb_configured(ucfg), .usb_suspend(usus), .sof_pulse(sof),
        .charger_detect(chg), .bitbang_write_strobe_n(wr_n),
        .bitbang_read_strobe_n(rd_n), .gpio_out(g_out), .gpio_oe(g_oe),
        .gpio_in_q(g_in), .tx_empty(txe), .rx_full(rxf),
        .bus_power_sense_used_q(bp_used), .bus_power_present_q(bp_on),
        .suspend_inhibit_q(inhibit), .power_enable_n_q(pwr_n),
        .aux_pin_in(pin), .aux_pin_out_q(out), .aux_pin_oe_q(oe),
        .aux_pin_pull_up_q(pu), .aux_pin_pull_down_q(pd));

    aux_board #(.BOARD_PD(6'h01)) aux_board_inst (
        .clk(clk), .out(out), .oe(oe), .pu(pu), .pd(pd),
        .ext_en(ext_en), .ext_val(ext_val), .lvl(pin));

    task end_of_test;
        begin
            if (n_errors == 0 && checked > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask

    task chk(input [31:0] seen, input [31:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                n_errors = n_errors + 1;
                $display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
            end
        end
    endtask

    task step(input integer n);
        repeat (n) @(negedge clk);
    endtask

    task load(input [29:0] s);
        begin
            sel = s;
            ld = 1'b1;
            step(1);
            ld = 1'b0;
            step(3);
        end
    endtask

    // counts transitions of the selector's out register over n cycles into base
    task span(input integer n);
        begin
            for (k = 0; k < 6; k = k + 1)
                base[k] = cnt[k];
            step(n);
            for (k = 0; k < 6; k = k + 1)
                base[k] = cnt[k] - base[k];
        end
    endtask

    always @(posedge clk) begin
        cyc = cyc + 1;
        for (m = 0; m < 6; m = m + 1)
            if (out[m] !== prev[m])
                cnt[m] = cnt[m] + 1;
        prev = out;
        if (cyc == 5000) begin
            n_errors = n_errors + 1;
            end_of_test;
        end
    end

    initial begin
        for (k = 0; k < 6; k = k + 1)
            cnt[k] = 0;
        step(2);
        rstn = 1'b1;
        chk({oe, pd, pu, pwr_n, loaded}, {12'h000, 6'h3f, 2'b10});
        g_oe = 4'h1;
        g_out = 4'h1;
        load({5'h1f, `SEL_GPIO, `SEL_DRIVE_ZERO, `SEL_DRIVE_ONE,
              `SEL_HIGH_Z, `SEL_GPIO});
        chk(loaded, 1'b1);
        chk(oe, 6'h0d);
        chk(out & oe, 6'h05);
        chk(pu & 6'h32, 6'h32);
        g_oe = 4'h0;
        ext_en = 6'h01;
        for (k = 0; k < 2; k = k + 1) begin
            ext_val = {5'h00, k[0]};
            step(5);
            chk(g_in, k);
        end
        ext_en = 6'h00;
        pd_opt = 1'b1;
        load({`SEL_BB_READ, `SEL_BB_WRITE, `SEL_RX_FULL, `SEL_TX_EMPTY,
              `SEL_SLEEP, `SEL_POWER_ENABLE});
        for (e = 0; e < 4; e = e + 1) begin
            ucfg = (e != 0);
            usus = (e == 2);
            txe = e[0];
            rxf = e[1];
            wr_n = ~e[0];
            rd_n = e[0];
            step(4);
            chk(oe, 6'h3f);
            chk(pwr_n, (e == 0 || e == 2));
            chk(out, {rd_n, wr_n, ~rxf, ~txe, ~usus,
                      (e == 0 || e == 2)});
        end
        usus = 1'b0;
        load({20'h0, `SEL_CHARGER_N, `SEL_CHARGER});
        for (e = 0; e < 2; e = e + 1) begin
            chg = e[0];
            step(4);
            chk({oe[1:0], out[1:0]}, {chg, 2'b10, chg});
        end
        pd_opt = 1'b1;
        ext_en = 6'h30;
        ext_val = 6'h30;
        load({`SEL_KEEP_AWAKE, `SEL_BUS_POWER, `SEL_TIMESTAMP,
              `SEL_CLK_SLOW, `SEL_CLK_MID, `SEL_CLK_FAST});
        span(1000);
        for (j = 0; j < 3; j = j + 1) begin
            e = (`CLK_FAST_KHZ >> j) * 1000 * 2 / `SYS_CLK_KHZ;
            chk(base[j] >= e - 2 && base[j] <= e + 2, 1'b1);
        end
        j = cnt[3];
        for (k = 0; k < 5; k = k + 1) begin
            sof = 1'b1;
            step(1);
            sof = 1'b0;
            step(1);
        end
        step(3);
        chk(cnt[3] - j, 5);
        chk({oe[5:4], pu[5:4]}, 4'h3);
        chk({bp_used, bp_on, inhibit}, 3'b110);
        ext_val = 6'h00;
        step(5);
        chk({bp_used, bp_on, inhibit}, 3'b101);
        usus = 1'b1;
        step(5);
        span(100);
        chk(base[0] + base[1] + base[2], 0);
        chk({pd[5:4], pu[5:4]}, 4'hc);
        end_of_test;
    end
endmodule
